// file: sim/flash_pulse_timer_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the pulse timer
module flash_pulse_timer_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic [31:0]       prdata_o,
  input wire logic              pslverr_o,
  input wire logic              array_req_i,
  input wire logic              array_write_i,
  input wire logic              array_err_o,
  input wire logic              hv_pulse_o,
  input wire logic              pump_clk_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Decode of the three mapped words
  wire logic mapped = (paddr_i == flash_pulse_timer_pkg::ADDR_CONTROL) ||
                      (paddr_i == flash_pulse_timer_pkg::ADDR_IRQ_STATUS) ||
                      (paddr_i == flash_pulse_timer_pkg::ADDR_IRQ_MASK);

  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero when idle");
  err_decode_a: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("slave error does not match decode");
  array_err_cause_a: assert property (array_err_o |-> $past(array_req_i))
    else $error("array error without request");
  array_err_pulse_a: assert property (hv_pulse_o && array_req_i |=> array_err_o)
    else $error("array access during pulse not refused");
  pump_in_pulse_a: assert property (pump_clk_o |-> hv_pulse_o || $past(hv_pulse_o))
    else $error("pump tick outside pulse");
  reset_quiet_a: assert property ($rose(rstn_i) |-> !hv_pulse_o && !irq_o && !pready_o)
    else $error("outputs active after reset");

  // Main scenarios reached
  cover property ($rose(hv_pulse_o));
  cover property (array_err_o);
  cover property (irq_o);
  cover property (pslverr_o);
endmodule

bind flash_pulse_timer flash_pulse_timer_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .array_req_i(array_req_i),
  .array_write_i(array_write_i), .array_err_o(array_err_o), .hv_pulse_o(hv_pulse_o),
  .pump_clk_o(pump_clk_o), .irq_o(irq_o)
);

// file: sim/flash_pulse_timer_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Register level bench for the pulse timer
module flash_pulse_timer_tb;
  localparam logic [11:0] a_ctl = flash_pulse_timer_pkg::ADDR_CONTROL;
  localparam logic [11:0] a_sts = flash_pulse_timer_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] a_msk = flash_pulse_timer_pkg::ADDR_IRQ_MASK;
  localparam int          limit = 50000; // Longest pulse is 32768 clocks

  logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, array_req_i, array_write_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic        pready_o, pslverr_o, array_err_o, hv_pulse_o, pump_clk_o, irq_o, e;
  int          n_fail, samples_checked, cyc, n, t0;
  // Range, exponent, multiplier, erase; pulse width; recovery clocks
  logic [31:0] cfg[6] = '{32'h0000_0010, 32'h0001_0140, 32'h0000_0020, 32'h0000_0014,
                          32'h0000_0030, 32'h0000_0050};
  int          wid[6] = '{32, 384, 48, 32768, 64, 128};
  int          rec[6] = '{48, 144, 72, 48, 96, 192};

  flash_pulse_timer dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .array_req_i(array_req_i),
    .array_write_i(array_write_i), .array_err_o(array_err_o), .hv_pulse_o(hv_pulse_o),
    .pump_clk_o(pump_clk_o), .irq_o(irq_o)
  );

  // ==========================================================
  // Clock, steady through every pulse, and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == limit) begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is sampled high
  task automatic xs(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Array write; also arms the enable while a sequence is started
  task automatic acc(input logic exp_err);
    @(posedge clk_i);
    array_req_i <= 1'b1;
    array_write_i <= 1'b1;
    @(posedge clk_i);
    array_req_i <= 1'b0;
    array_write_i <= 1'b0;
    #1 chk({31'h0, array_err_o}, {31'h0, exp_err});
  endtask

  // Reads control until the status bit drops; poll adds a few clocks of slack
  task automatic poll();
    q = 32'h8;
    while (q[3] !== 1'b0) xs(1'b0, a_ctl, 32'h0);
    n = cyc - t0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, array_req_i, array_write_i} = 5'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    rstn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'h0);
    xs(1'b0, a_sts, 32'h0);
    chk(q, 32'h0);
    xs(1'b0, a_msk, 32'h0);
    chk(q, 32'h0);
    // Status bit ignores writes, enable needs an armed start; other fields land
    xs(1'b1, a_ctl, 32'hFFFF_FFFF);
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'h077F_0376);
    xs(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    xs(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h0);
    repeat (2) xs(1'b1, a_ctl, 32'h0);
    // Untimed range: only software ends the pulse, interrupt masked
    xs(1'b1, a_ctl, 32'h2);
    xs(1'b1, a_ctl, 32'h3);
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'h2);
    acc(1'b0);
    xs(1'b1, a_ctl, 32'h3);
    while (hv_pulse_o !== 1'b1) @(posedge clk_i);
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'hB);
    acc(1'b1);
    xs(1'b1, a_ctl, 32'h1);
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'hB);
    repeat (200) @(posedge clk_i);
    chk({31'h0, hv_pulse_o}, 32'h1);
    xs(1'b1, a_ctl, 32'h2);
    t0 = cyc;
    poll();
    chk({31'h0, (n >= 126 && n <= 140)}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    xs(1'b0, a_sts, 32'h0);
    chk(q, 32'h5);
    acc(1'b0);
    repeat (2) xs(1'b1, a_ctl, 32'h0);
    // Timed pulses over a table of ranges, exponents and multipliers
    xs(1'b1, a_msk, 32'h1);
    for (int i = 0; i < 6; i++) begin
      xs(1'b1, a_ctl, cfg[i] | 32'h2);
      acc(1'b0);
      xs(1'b1, a_ctl, cfg[i] | 32'h3);
      while (hv_pulse_o !== 1'b1) @(posedge clk_i);
      n = 0;
      while (hv_pulse_o === 1'b1) begin
        @(posedge clk_i);
        n++;
      end
      chk({31'h0, (n >= wid[i] - 1 && n <= wid[i] + 4)}, 32'h1);
      t0 = cyc;
      poll();
      chk({31'h0, (n >= rec[i] - 2 && n <= rec[i] + 8)}, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      xs(1'b0, a_sts, 32'h0);
      chk(q, 32'h3);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      repeat (3) xs(1'b1, a_ctl, 32'h0);
    end
    xs(1'b0, a_ctl, 32'h0);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule

// file: verilog/flash_clock_scaler.sv
`timescale 1ns/100ps

module flash_clock_scaler (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] range_i,
  input  wire logic       run_i,
  output logic            tick_o
);

  // ==========================================================================
  // Fractional prescaler: den ticks per num system clocks
  logic [2:0] acc;
  logic [2:0] num;
  logic [2:0] den;
  logic [3:0] sum;
  logic       fire;

  // Ratio per range code; reserved codes fall back to a scaling of 1
  always_comb begin
    unique case (range_i)
      flash_pulse_timer_pkg::RANGE_12_18: begin
        num = 3'h3;
        den = 3'h2;
      end
      flash_pulse_timer_pkg::RANGE_18_24: begin
        num = 3'h2;
        den = 3'h1;
      end
      flash_pulse_timer_pkg::RANGE_24_36: begin
        num = 3'h3;
        den = 3'h1;
      end
      flash_pulse_timer_pkg::RANGE_36_40: begin
        num = 3'h4;
        den = 3'h1;
      end
      default: begin
        num = 3'h1;
        den = 3'h1;
      end
    endcase
  end

  // The 3/2 case alternates one and two clocks, average period 1.5
  assign sum  = {1'b0, acc} + {1'b0, den};
  assign fire = (sum >= {1'b0, num});

  // Phase restarts whenever the timer is idle, so each pulse is aligned
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i) begin
      acc    <= 3'h0;
      tick_o <= 1'b0;
    end else begin
      acc    <= fire ? 3'(sum - {1'b0, num}) : sum[2:0];
      tick_o <= fire;
    end
  end

endmodule

// file: verilog/flash_pulse_timer.sv
`timescale 1ns/100ps
// Functional notes
// (R1) Status bit is read only; writes never change it.
// (R2) Status bit is one during pulse and recovery, zero otherwise.
// (R3) While status is one: array access errors, start bit changes ignored.
// (R4) Pulse starts on enable set; ends on enable clear or timer expiry.
// (R5) Recovery lasts 48 scaled clocks, or 128 clocks when range is 000.
// (R6) After reset the status bit reads zero.
// (R7) Pulse width is clock period times R times 2^N times M.
// (R8) N is 5 plus exponent field, plus 10 when erasing.
// (R9) M is one plus the seven-bit multiplier field.
// (R10) Range field selects R: 010 gives 3/2, 100 gives 3.
// (R11) A scaled clock of period times R drives pump and exponent stage.
// (R12) Range resets to 000; then only software ends the pulse.
// (R13) Exponent field resets to 00.
// (R14) Range and exponent stay writable while a sequence is started.
// (R15) Clock frequency is not monitored; slow clocks are not blocked.
// (R16) System clock must stay constant during program or erase.
// (R17) Enable sets only after start and a valid array write since then.
// (R18) Timer is prescaler, binary stage, then linear stage; expiry ends pulse.

module flash_pulse_timer #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  input  wire logic              array_req_i,
  input  wire logic              array_write_i,
  output logic                   array_err_o,
  output logic                   hv_pulse_o,
  output logic                   pump_clk_o,
  output logic                   irq_o
);

  // ==========================================================================
  // State and register storage
  flash_pulse_timer_pkg::pulse_state_t state;
  flash_pulse_timer_pkg::pulse_state_t next_state;

  logic                                         enable;
  logic                                         start;
  logic                                         erase;
  logic                                         status;
  logic                                         armed;
  logic [flash_pulse_timer_pkg::RANGE_W-1:0]    range_sel;
  logic [flash_pulse_timer_pkg::EXP_W-1:0]      exponent;
  logic [flash_pulse_timer_pkg::MULT_W-1:0]     multiplier;
  logic [flash_pulse_timer_pkg::PAW_W-1:0]      amp_width;
  logic [flash_pulse_timer_pkg::IRQ_W-1:0]      irq_status;
  logic [flash_pulse_timer_pkg::IRQ_W-1:0]      irq_mask;
  logic [flash_pulse_timer_pkg::TIMER_W-1:0]    exp_cnt;
  logic [flash_pulse_timer_pkg::MULT_W-1:0]     mult_cnt;
  logic [flash_pulse_timer_pkg::RECOVERY_W-1:0] rec_cnt;

  // ==========================================================================
  // APB decode
  wire access      = psel_i & penable_i;
  wire done        = access & pready_o;
  wire wr_done     = done & pwrite_i;
  wire sel_control = (paddr_i == flash_pulse_timer_pkg::ADDR_CONTROL);
  wire sel_status  = (paddr_i == flash_pulse_timer_pkg::ADDR_IRQ_STATUS);
  wire sel_mask    = (paddr_i == flash_pulse_timer_pkg::ADDR_IRQ_MASK);
  wire addr_hit    = sel_control | sel_status | sel_mask;
  wire wr_control  = wr_done & sel_control;
  wire wr_mask     = wr_done & sel_mask;
  wire rd_status   = done & ~pwrite_i & sel_status;

  // Assembled control word; status is reflected here, never stored from bus
  logic [31:0] control_word;
  always_comb begin
    control_word = 32'h0000_0000;
    control_word[flash_pulse_timer_pkg::ENABLE_BIT] = enable;
    control_word[flash_pulse_timer_pkg::START_BIT]  = start;
    control_word[flash_pulse_timer_pkg::ERASE_BIT]  = erase;
    control_word[flash_pulse_timer_pkg::STATUS_BIT] = status;
    control_word[flash_pulse_timer_pkg::RANGE_LSB +: flash_pulse_timer_pkg::RANGE_W] = range_sel;
    control_word[flash_pulse_timer_pkg::EXP_LSB +: flash_pulse_timer_pkg::EXP_W]     = exponent;
    control_word[flash_pulse_timer_pkg::MULT_LSB +: flash_pulse_timer_pkg::MULT_W]   = multiplier;
    control_word[flash_pulse_timer_pkg::PAW_LSB +: flash_pulse_timer_pkg::PAW_W]     = amp_width;
  end

  wire [31:0] read_mux =
    sel_control ? control_word :
    sel_status  ? {{(32 - flash_pulse_timer_pkg::IRQ_W){1'b0}}, irq_status} :
    sel_mask    ? {{(32 - flash_pulse_timer_pkg::IRQ_W){1'b0}}, irq_mask} :
                  32'h0000_0000;

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= access & ~pready_o;
      prdata_o  <= (access & ~pready_o & ~pwrite_i) ? read_mux : 32'h0000_0000;
      pslverr_o <= access & ~pready_o & ~addr_hit;
    end
  end

  // ==========================================================================
  // Write field extraction
  wire                                      wd_enable = pwdata_i[flash_pulse_timer_pkg::ENABLE_BIT];
  wire                                      wd_start  = pwdata_i[flash_pulse_timer_pkg::START_BIT];
  wire                                      wd_erase  = pwdata_i[flash_pulse_timer_pkg::ERASE_BIT];
  wire [flash_pulse_timer_pkg::RANGE_W-1:0] wd_range  =
    pwdata_i[flash_pulse_timer_pkg::RANGE_LSB +: flash_pulse_timer_pkg::RANGE_W];
  wire [flash_pulse_timer_pkg::EXP_W-1:0]   wd_exp    =
    pwdata_i[flash_pulse_timer_pkg::EXP_LSB +: flash_pulse_timer_pkg::EXP_W];
  wire [flash_pulse_timer_pkg::MULT_W-1:0]  wd_mult   =
    pwdata_i[flash_pulse_timer_pkg::MULT_LSB +: flash_pulse_timer_pkg::MULT_W];
  wire [flash_pulse_timer_pkg::PAW_W-1:0]   wd_paw    =
    pwdata_i[flash_pulse_timer_pkg::PAW_LSB +: flash_pulse_timer_pkg::PAW_W];

  // Permissions use values before this write, so same-cycle writes
  // of start and enable judge each other by their old state
  wire start_ok   = wr_control & ~status & ~enable;              // [R3]
  wire erase_ok   = wr_control & ~start;
  wire paw_ok     = wr_control & ~status;
  wire enable_set = wr_control & wd_enable & ~enable & start & wd_start & armed; // [R17]
  wire enable_clr = wr_control & ~wd_enable;

  // Interlock write: array write inside a started sequence before the pulse
  wire array_accept = array_req_i & array_write_i & start & ~status & ~enable;

  // ==========================================================================
  // Control register fields
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      enable     <= 1'b0;
      start      <= 1'b0;
      erase      <= 1'b0;
      range_sel  <= flash_pulse_timer_pkg::RANGE_RESET;  // [R12]
      exponent   <= flash_pulse_timer_pkg::EXP_RESET;    // [R13]
      multiplier <= flash_pulse_timer_pkg::MULT_RESET;
      amp_width  <= flash_pulse_timer_pkg::PAW_RESET;
    end else begin
      if (enable_set) begin
        enable <= 1'b1;
      end else if (enable_clr) begin
        enable <= 1'b0;
      end
      if (start_ok) begin
        start <= wd_start;
      end
      if (erase_ok) begin
        erase <= wd_erase;
      end
      // Timing fields are not locked by a started sequence
      if (wr_control) begin
        range_sel  <= wd_range;   // [R14]
        exponent   <= wd_exp;     // [R14]
        multiplier <= wd_mult;
      end
      if (paw_ok) begin
        amp_width <= wd_paw;
      end
    end
  end

  // Interlock flag, dropped whenever the sequence is not started
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      armed <= 1'b0;
    end else if (!start) begin
      armed <= 1'b0;
    end else if (array_accept) begin
      armed <= 1'b1;              // [R17]
    end
  end

  // ==========================================================================
  // Pulse timer cascade
  logic tick;

  wire run = (state == flash_pulse_timer_pkg::ST_PULSE) |
             (state == flash_pulse_timer_pkg::ST_RECOVER);

  // Scaled clock: one tick per R system clocks, shared with the pump [R11]
  flash_clock_scaler u_scaler (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .range_i (range_sel),
    .run_i   (run),
    .tick_o  (tick)
  );

  // Reserved codes run untimed, like 000, rather than guess a ratio
  wire timed = (range_sel >= flash_pulse_timer_pkg::RANGE_8_12) &
               (range_sel <= flash_pulse_timer_pkg::RANGE_36_40);  // [R10] [R12]

  // No clock-frequency check exists; slow clocks only stretch the pulse [R15]
  // Exponent N = base + field, + extra decade for erase
  wire [4:0] exp_n = 5'(flash_pulse_timer_pkg::EXP_BASE) + {3'h0, exponent} +
                     (erase ? 5'(flash_pulse_timer_pkg::EXP_ERASE_ADD) : 5'h00);  // [R8]

  // 2^N - 1; at N = 18 the shift wraps to zero and the subtract gives all ones
  wire [flash_pulse_timer_pkg::TIMER_W-1:0] exp_limit =
    (flash_pulse_timer_pkg::TIMER_W'(1) << exp_n) - flash_pulse_timer_pkg::TIMER_W'(1);

  wire exp_last  = (exp_cnt == exp_limit);
  wire mult_last = (mult_cnt == multiplier);  // M = field + 1 passes [R9]
  // Width = period x R x 2^N x M, counted as ticks through both stages [R7]
  wire expire    = timed & tick & exp_last & mult_last;  // [R18]

  // Binary stage feeds linear stage; both clear outside the pulse
  always_ff @(posedge clk_i) begin
    if (!rstn_i || state != flash_pulse_timer_pkg::ST_PULSE) begin
      exp_cnt  <= '0;
      mult_cnt <= '0;
    end else if (tick) begin
      exp_cnt <= exp_last ? '0 : exp_cnt + 1'b1;             // [R18]
      if (exp_last) begin
        mult_cnt <= mult_cnt + 1'b1;                         // [R18]
      end
    end
  end

  // ==========================================================================
  // Recovery counter
  wire rec_step = timed ? tick : 1'b1;
  wire rec_last = timed ?
    (rec_cnt == flash_pulse_timer_pkg::RECOVERY_W'(flash_pulse_timer_pkg::RECOVERY_TICKS - 1)) :
    (rec_cnt == flash_pulse_timer_pkg::RECOVERY_W'(flash_pulse_timer_pkg::RECOVERY_CLOCKS - 1));
  wire rec_done = rec_step & rec_last;  // [R5]

  always_ff @(posedge clk_i) begin
    if (!rstn_i || state != flash_pulse_timer_pkg::ST_RECOVER) begin
      rec_cnt <= '0;
    end else if (rec_step) begin
      rec_cnt <= rec_cnt + 1'b1;  // [R5]
    end
  end

  // ==========================================================================
  // Pulse sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      flash_pulse_timer_pkg::ST_IDLE: begin
        if (enable) begin
          next_state = flash_pulse_timer_pkg::ST_PULSE;    // [R4]
        end
      end
      flash_pulse_timer_pkg::ST_PULSE: begin
        if (!enable || expire) begin
          next_state = flash_pulse_timer_pkg::ST_RECOVER;  // [R4]
        end
      end
      flash_pulse_timer_pkg::ST_RECOVER: begin
        if (rec_done) begin
          next_state = enable ? flash_pulse_timer_pkg::ST_HOLD :
                                flash_pulse_timer_pkg::ST_IDLE;
        end
      end
      flash_pulse_timer_pkg::ST_HOLD: begin
        // Timer ended the pulse; wait for software to drop enable
        if (!enable) begin
          next_state = flash_pulse_timer_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Status is owned by the sequencer alone, never by the bus [R1]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state      <= flash_pulse_timer_pkg::ST_IDLE;
      status     <= 1'b0;                                   // [R6]
      hv_pulse_o <= 1'b0;
      pump_clk_o <= 1'b0;
    end else begin
      state      <= next_state;
      status     <= (next_state == flash_pulse_timer_pkg::ST_PULSE) |
                    (next_state == flash_pulse_timer_pkg::ST_RECOVER);  // [R2]
      hv_pulse_o <= (next_state == flash_pulse_timer_pkg::ST_PULSE);
      pump_clk_o <= tick & (state == flash_pulse_timer_pkg::ST_PULSE);  // [R11]
    end
  end

  // Array accesses during high voltage get a bus error
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      array_err_o <= 1'b0;
    end else begin
      array_err_o <= array_req_i & status;  // [R3]
    end
  end

  // ==========================================================================
  // Interrupts: sticky events, read clears, a new event beats the clear
  logic [flash_pulse_timer_pkg::IRQ_W-1:0] irq_set;
  logic [flash_pulse_timer_pkg::IRQ_W-1:0] next_irq_status;

  always_comb begin
    irq_set = '0;
    irq_set[flash_pulse_timer_pkg::IRQ_PULSE_DONE] =
      (state == flash_pulse_timer_pkg::ST_RECOVER) & rec_done;
    irq_set[flash_pulse_timer_pkg::IRQ_TIMER_EXPIRY] =
      (state == flash_pulse_timer_pkg::ST_PULSE) & expire;
    irq_set[flash_pulse_timer_pkg::IRQ_ARRAY_ERROR] = array_req_i & status;
    // Clear only what the read returned, so an event after the capture survives
    next_irq_status = (rd_status ?
                       (irq_status & ~prdata_o[flash_pulse_timer_pkg::IRQ_W-1:0]) :
                       irq_status) | irq_set;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= pwdata_i[flash_pulse_timer_pkg::IRQ_W-1:0];
      end
      irq_o <= |(next_irq_status & (wr_mask ? pwdata_i[flash_pulse_timer_pkg::IRQ_W-1:0] :
                                              irq_mask));
    end
  end

  // Software must hold the system clock steady during a pulse; nothing here
  // can correct a changed rate, the counts simply stretch or shrink

endmodule

// file: verilog/flash_pulse_timer_pkg.sv
package flash_pulse_timer_pkg;

  // ==========================================================================
  // Register map, byte addresses on the APB word grid
  localparam logic [11:0] ADDR_CONTROL    = 12'h000;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h008;

  // ==========================================================================
  // Field positions of high_voltage_control
  localparam int ENABLE_BIT  = 0;   // high_voltage_enable
  localparam int START_BIT   = 1;   // sequence_start
  localparam int ERASE_BIT   = 2;   // erase select
  localparam int STATUS_BIT  = 3;   // high_voltage_status, read only
  localparam int RANGE_LSB   = 4;   // clock_range_select[2:0]
  localparam int RANGE_W     = 3;
  localparam int EXP_LSB     = 8;   // clock_period_exponent[1:0]
  localparam int EXP_W       = 2;
  localparam int MULT_LSB    = 16;  // clock_period_multiplier[6:0]
  localparam int MULT_W      = 7;
  localparam int PAW_LSB     = 24;  // pulse_amplitude_width[2:0]
  localparam int PAW_W       = 3;

  // ==========================================================================
  // Reset values
  localparam logic [RANGE_W-1:0] RANGE_RESET = 3'h0;
  localparam logic [EXP_W-1:0]   EXP_RESET   = 2'h0;
  localparam logic [MULT_W-1:0]  MULT_RESET  = 7'h00;
  localparam logic [PAW_W-1:0]   PAW_RESET   = 3'h0;

  // ==========================================================================
  // Clock range codes
  localparam logic [RANGE_W-1:0] RANGE_UNTIMED = 3'h0;
  localparam logic [RANGE_W-1:0] RANGE_8_12    = 3'h1;
  localparam logic [RANGE_W-1:0] RANGE_12_18   = 3'h2;
  localparam logic [RANGE_W-1:0] RANGE_18_24   = 3'h3;
  localparam logic [RANGE_W-1:0] RANGE_24_36   = 3'h4;
  localparam logic [RANGE_W-1:0] RANGE_36_40   = 3'h5;

  // ==========================================================================
  // Timing figures
  localparam int TIMER_W          = 18;  // Widest binary stage, N up to 18
  localparam int EXP_BASE         = 5;
  localparam int EXP_ERASE_ADD    = 10;
  localparam int RECOVERY_TICKS   = 48;  // Scaled clocks
  localparam int RECOVERY_CLOCKS  = 128; // System clocks, untimed range
  localparam int RECOVERY_W       = 8;

  // ==========================================================================
  // Interrupt status bits
  localparam int IRQ_W            = 3;
  localparam int IRQ_PULSE_DONE   = 0;
  localparam int IRQ_TIMER_EXPIRY = 1;
  localparam int IRQ_ARRAY_ERROR  = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE,
    ST_RECOVER,
    ST_HOLD
  } pulse_state_t;

endpackage
